/* File: design/conv_ctl_pkg.sv */
// Purpose: constants and carrier types for the dual converter control block
// Assumes: 8-bit register port, one system clock, active-low async reset
// Notes:   register offsets are byte addresses on the plain register port
package conv_ctl_pkg;

  // register offsets
  localparam logic [7:0] PREC_CTL_ADDR  = 8'h00;
  localparam logic [7:0] PREC_CFG_ADDR  = 8'h01;
  localparam logic [7:0] PREC_PAIR_ADDR = 8'h02;
  localparam logic [7:0] PREC_RESL_ADDR = 8'h03;
  localparam logic [7:0] PREC_RESH_ADDR = 8'h04;
  localparam logic [7:0] WIN_LOL_ADDR   = 8'h05;
  localparam logic [7:0] WIN_LOH_ADDR   = 8'h06;
  localparam logic [7:0] WIN_HIL_ADDR   = 8'h07;
  localparam logic [7:0] WIN_HIH_ADDR   = 8'h08;
  localparam logic [7:0] WIN_CTL_ADDR   = 8'h09;
  localparam logic [7:0] FAST_CTL_ADDR  = 8'h0A;
  localparam logic [7:0] FAST_CFG_ADDR  = 8'h0B;
  localparam logic [7:0] FAST_RES_ADDR  = 8'h0C;

  // precision control register fields
  localparam int P_EN_BIT    = 0;
  localparam int P_SRC_LSB   = 1;
  localparam int P_LJ_BIT    = 3;
  localparam int P_GO_BIT    = 4;
  localparam int P_DONE_BIT  = 5;
  localparam int P_BUSY_BIT  = 6;
  localparam int P_IE_BIT    = 7;
  // precision config register fields
  localparam int PC_CH_LSB   = 0;
  localparam int PC_GAIN_LSB = 4;
  localparam int PC_REF_BIT  = 7;
  // window control register fields
  localparam int W_INSIDE_BIT = 0;
  localparam int W_IE_BIT     = 1;
  localparam int W_FLAG_BIT   = 2;
  localparam int W_BG_BIT     = 3;
  // fast control register fields
  localparam int F_EN_BIT    = 0;
  localparam int F_SRC_LSB   = 1;
  localparam int F_GO_BIT    = 3;
  localparam int F_DONE_BIT  = 4;
  localparam int F_BUSY_BIT  = 5;
  localparam int F_IE_BIT    = 6;
  // fast config register fields
  localparam int FC_CH_LSB   = 0;
  localparam int FC_GAIN_LSB = 3;
  localparam int FC_REF_BIT  = 5;

  // precision start sources
  localparam logic [1:0] P_SRC_SW   = 2'h0;
  localparam logic [1:0] P_SRC_TMR2 = 2'h1;
  localparam logic [1:0] P_SRC_TMR3 = 2'h2;
  localparam logic [1:0] P_SRC_EXT  = 2'h3;
  // fast start sources
  localparam logic [1:0] F_SRC_SW   = 2'h0;
  localparam logic [1:0] F_SRC_TMR  = 2'h1;
  localparam logic [1:0] F_SRC_EXT  = 2'h2;
  localparam logic [1:0] F_SRC_SYNC = 2'h3;

  // gain codes: 0=0.5 1=1 2=2 3=4 4=8 5=16
  localparam logic [2:0] P_GAIN_MAX  = 3'h5;
  // channel 8 is the temperature sensor
  localparam logic [3:0] P_CH_TEMP   = 4'h8;
  localparam int         P_RES_BITS  = 12;
  localparam int         P_NARROW    = 10;
  localparam int         P_PAIRS     = 4;

  // reset values
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [15:0] WIN_HI_RST = 16'hFFFF;

  // analog-side controls of the precision converter
  typedef struct packed {
    logic       shutdown;
    logic       ref_pin;   // 1: precision_ref_pin, 0: first_dac_output
    logic [2:0] gain;
    logic [3:0] pair_diff;
    logic [3:0] mux_sel;
  } prec_ana_s;

  // analog-side controls of the fast converter
  typedef struct packed {
    logic       shutdown;
    logic       ref_pin;   // 1: fast_ref_pin, 0: analog_supply_rail
    logic [1:0] gain;
    logic [2:0] mux_sel;
  } fast_ana_s;

endpackage

/* File: design/dual_adc_conversion_control.sv */
// Purpose: digital control of the precision and fast converters
// Assumes: converter cores answer a start pulse with a done pulse and data
// Notes:   external start pins are synchronised; all other inputs share ref_clk
`timescale 1ns/1ps
module dual_adc_conversion_control #(
  parameter bit NARROW_RESULT = 1'b0  // 1: reduced 10-bit precision variant
) (
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  // register port
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  // start sources
  input  wire logic                     tmr2_ovf,
  input  wire logic                     tmr3_ovf,
  input  wire logic                     fast_tmr_ovf,
  input  wire logic                     prec_ext_start,
  input  wire logic                     fast_ext_start,
  // precision converter core
  output conv_ctl_pkg::prec_ana_s       prec_ana,
  output logic                          prec_start,
  input  wire logic                     prec_done,
  input  wire logic [11:0]              prec_data,
  // fast converter core
  output conv_ctl_pkg::fast_ana_s       fast_ana,
  output logic                          fast_start,
  input  wire logic                     fast_done,
  input  wire logic [7:0]               fast_data,
  // interrupt requests
  output logic                          prec_irq,
  output logic                          win_irq,
  output logic                          fast_irq
);

  // precision control state
  logic        p_en_ff;
  logic [1:0]  p_src_ff;
  logic        p_lj_ff;
  logic        p_done_ff;
  logic        p_busy_ff;
  logic        p_ie_ff;
  logic [3:0]  p_ch_ff;
  logic [2:0]  p_gain_ff;
  logic        p_ref_ff;
  logic [3:0]  p_pair_ff;
  logic [15:0] p_res_ff;
  logic [15:0] win_lo_ff;
  logic [15:0] win_hi_ff;
  logic        w_inside_ff;
  logic        w_ie_ff;
  logic        w_flag_ff;
  logic        w_bg_ff;
  // fast control state
  logic        f_en_ff;
  logic [1:0]  f_src_ff;
  logic        f_done_ff;
  logic        f_busy_ff;
  logic        f_ie_ff;
  logic [2:0]  f_ch_ff;
  logic [1:0]  f_gain_ff;
  logic        f_ref_ff;
  logic [7:0]  f_res_ff;
  // synchronisers and edge detect for external starts
  logic [2:0]  p_ext_sync_ff;
  logic [2:0]  f_ext_sync_ff;
  // output registers
  logic [7:0]  rdata_ff;
  logic        p_start_ff;
  logic        f_start_ff;
  logic        p_irq_ff;
  logic        w_irq_ff;
  logic        f_irq_ff;

  // decoded register writes, start triggers and next-value signals
  logic        wr_pctl;
  logic        wr_pcfg;
  logic        wr_wctl;
  logic        wr_fctl;
  logic        wr_fcfg;
  logic        wr_pair;
  logic        wr_wlol;
  logic        wr_wloh;
  logic        wr_whil;
  logic        wr_whih;
  logic        p_sw_go;
  logic        p_trig;
  logic        p_accept;
  logic        f_trig;
  logic        f_accept;
  logic        p_ext_rise;
  logic        f_ext_rise;
  logic [15:0] nxt_p_res;
  logic        win_in_range;
  logic        win_hit;
  logic [3:0]  nxt_p_ch;
  logic [2:0]  nxt_p_gain;

  // one write strobe per writable register offset
  assign wr_pctl = reg_wr && (reg_addr == conv_ctl_pkg::PREC_CTL_ADDR);
  assign wr_pcfg = reg_wr && (reg_addr == conv_ctl_pkg::PREC_CFG_ADDR);
  assign wr_wctl = reg_wr && (reg_addr == conv_ctl_pkg::WIN_CTL_ADDR);
  assign wr_fctl = reg_wr && (reg_addr == conv_ctl_pkg::FAST_CTL_ADDR);
  assign wr_fcfg = reg_wr && (reg_addr == conv_ctl_pkg::FAST_CFG_ADDR);
  assign wr_pair = reg_wr && (reg_addr == conv_ctl_pkg::PREC_PAIR_ADDR);
  assign wr_wlol = reg_wr && (reg_addr == conv_ctl_pkg::WIN_LOL_ADDR);
  assign wr_wloh = reg_wr && (reg_addr == conv_ctl_pkg::WIN_LOH_ADDR);
  assign wr_whil = reg_wr && (reg_addr == conv_ctl_pkg::WIN_HIL_ADDR);
  assign wr_whih = reg_wr && (reg_addr == conv_ctl_pkg::WIN_HIH_ADDR);

  // two-flop synchronisers, third stage only for edge detect
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      p_ext_sync_ff <= 3'h0;
      f_ext_sync_ff <= 3'h0;
    end else begin
      p_ext_sync_ff <= {p_ext_sync_ff[1:0], prec_ext_start};
      f_ext_sync_ff <= {f_ext_sync_ff[1:0], fast_ext_start};
    end
  end

  // rise seen between the second and third stage, so no false edge after reset
  assign p_ext_rise = p_ext_sync_ff[1] && !p_ext_sync_ff[2];
  assign f_ext_rise = f_ext_sync_ff[1] && !f_ext_sync_ff[2];

  // precision start: exactly the selected source counts
  assign p_sw_go = wr_pctl && reg_wdata[conv_ctl_pkg::P_GO_BIT]
                   && (p_src_ff == conv_ctl_pkg::P_SRC_SW);
  always_comb begin
    unique case (p_src_ff)
      conv_ctl_pkg::P_SRC_SW:   p_trig = p_sw_go;
      conv_ctl_pkg::P_SRC_TMR2: p_trig = tmr2_ovf;
      conv_ctl_pkg::P_SRC_TMR3: p_trig = tmr3_ovf;
      conv_ctl_pkg::P_SRC_EXT:  p_trig = p_ext_rise;
    endcase
  end
  // shutdown and busy both block a start
  assign p_accept = p_trig && p_en_ff && !p_busy_ff;

  // fast start: software, timer, external or precision software start
  always_comb begin
    unique case (f_src_ff)
      conv_ctl_pkg::F_SRC_SW:   f_trig = wr_fctl && reg_wdata[conv_ctl_pkg::F_GO_BIT];
      conv_ctl_pkg::F_SRC_TMR:  f_trig = fast_tmr_ovf;
      conv_ctl_pkg::F_SRC_EXT:  f_trig = f_ext_rise;
      conv_ctl_pkg::F_SRC_SYNC: f_trig = p_sw_go && p_accept;
    endcase
  end
  assign f_accept = f_trig && f_en_ff && !f_busy_ff;

  // result justification: right keeps low bits, left packs to the top
  always_comb begin
    nxt_p_res = 16'h0000;
    if (NARROW_RESULT) begin
      if (p_lj_ff)
        nxt_p_res = {prec_data[conv_ctl_pkg::P_NARROW-1:0], 6'h00};
      else
        nxt_p_res = {6'h00, prec_data[conv_ctl_pkg::P_NARROW-1:0]};
    end else begin
      if (p_lj_ff)
        nxt_p_res = {prec_data, 4'h0};
      else
        nxt_p_res = {4'h0, prec_data};
    end
  end

  // window test on the justified value, limits included
  assign win_in_range = (nxt_p_res >= win_lo_ff) && (nxt_p_res <= win_hi_ff);
  assign win_hit      = w_inside_ff ? win_in_range : !win_in_range;

  // precision channel and gain writes saturate at their top legal codes
  always_comb begin
    nxt_p_ch   = reg_wdata[conv_ctl_pkg::PC_CH_LSB +: 4];
    nxt_p_gain = reg_wdata[conv_ctl_pkg::PC_GAIN_LSB +: 3];
    if (nxt_p_ch > conv_ctl_pkg::P_CH_TEMP)
      nxt_p_ch = conv_ctl_pkg::P_CH_TEMP;
    if (nxt_p_gain > conv_ctl_pkg::P_GAIN_MAX)
      nxt_p_gain = conv_ctl_pkg::P_GAIN_MAX;
  end

  // precision control and configuration registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      p_en_ff   <= 1'b0;
      p_src_ff  <= conv_ctl_pkg::P_SRC_SW;
      p_lj_ff   <= 1'b0;
      p_ie_ff   <= 1'b0;
      p_ch_ff   <= 4'h0;
      p_gain_ff <= 3'h1;
      p_ref_ff  <= 1'b0;
      p_pair_ff <= 4'h0;
    end else begin
      if (wr_pctl) begin
        p_en_ff  <= reg_wdata[conv_ctl_pkg::P_EN_BIT];
        p_src_ff <= reg_wdata[conv_ctl_pkg::P_SRC_LSB +: 2];
        p_lj_ff  <= reg_wdata[conv_ctl_pkg::P_LJ_BIT];
        p_ie_ff  <= reg_wdata[conv_ctl_pkg::P_IE_BIT];
      end
      if (wr_pcfg) begin
        p_ch_ff   <= nxt_p_ch;
        p_gain_ff <= nxt_p_gain;
        p_ref_ff  <= reg_wdata[conv_ctl_pkg::PC_REF_BIT];
      end
      if (wr_pair)
        p_pair_ff <= reg_wdata[conv_ctl_pkg::P_PAIRS-1:0];
    end
  end

  // precision busy, done flag and result latch
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      p_busy_ff <= 1'b0;
      p_done_ff <= 1'b0;
      p_res_ff  <= 16'h0000;
    end else begin
      if (p_accept)
        p_busy_ff <= 1'b1;
      else if (prec_done || !p_en_ff)
        p_busy_ff <= 1'b0;
      // a completion in the clearing cycle keeps the flag set
      if (prec_done && p_busy_ff) begin
        p_done_ff <= 1'b1;
        p_res_ff  <= nxt_p_res;
      end else if (wr_pctl && reg_wdata[conv_ctl_pkg::P_DONE_BIT]) begin
        p_done_ff <= 1'b0;
      end
    end
  end

  // window bounds and window control
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      win_lo_ff   <= 16'h0000;
      win_hi_ff   <= conv_ctl_pkg::WIN_HI_RST;
      w_inside_ff <= 1'b1;
      w_ie_ff     <= 1'b0;
      w_bg_ff     <= 1'b0;
      w_flag_ff   <= 1'b0;
    end else begin
      if (wr_wlol)
        win_lo_ff[7:0] <= reg_wdata;
      if (wr_wloh)
        win_lo_ff[15:8] <= reg_wdata;
      if (wr_whil)
        win_hi_ff[7:0] <= reg_wdata;
      if (wr_whih)
        win_hi_ff[15:8] <= reg_wdata;
      if (wr_wctl) begin
        w_inside_ff <= reg_wdata[conv_ctl_pkg::W_INSIDE_BIT];
        w_ie_ff     <= reg_wdata[conv_ctl_pkg::W_IE_BIT];
        w_bg_ff     <= reg_wdata[conv_ctl_pkg::W_BG_BIT];
      end
      // set wins over a clear in the same cycle
      if (prec_done && p_busy_ff && win_hit)
        w_flag_ff <= 1'b1;
      else if (wr_wctl && reg_wdata[conv_ctl_pkg::W_FLAG_BIT])
        w_flag_ff <= 1'b0;
    end
  end

  // fast control and configuration registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      f_en_ff   <= 1'b0;
      f_src_ff  <= conv_ctl_pkg::F_SRC_SW;
      f_ie_ff   <= 1'b0;
      f_ch_ff   <= 3'h0;
      f_gain_ff <= 2'h1;
      f_ref_ff  <= 1'b0;
    end else begin
      if (wr_fctl) begin
        f_en_ff  <= reg_wdata[conv_ctl_pkg::F_EN_BIT];
        f_src_ff <= reg_wdata[conv_ctl_pkg::F_SRC_LSB +: 2];
        f_ie_ff  <= reg_wdata[conv_ctl_pkg::F_IE_BIT];
      end
      if (wr_fcfg) begin
        f_ch_ff   <= reg_wdata[conv_ctl_pkg::FC_CH_LSB +: 3];
        f_gain_ff <= reg_wdata[conv_ctl_pkg::FC_GAIN_LSB +: 2];
        f_ref_ff  <= reg_wdata[conv_ctl_pkg::FC_REF_BIT];
      end
    end
  end

  // fast busy, done flag and result latch
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      f_busy_ff <= 1'b0;
      f_done_ff <= 1'b0;
      f_res_ff  <= 8'h00;
    end else begin
      if (f_accept)
        f_busy_ff <= 1'b1;
      else if (fast_done || !f_en_ff)
        f_busy_ff <= 1'b0;
      if (fast_done && f_busy_ff) begin
        f_done_ff <= 1'b1;
        f_res_ff  <= fast_data;
      end else if (wr_fctl && reg_wdata[conv_ctl_pkg::F_DONE_BIT]) begin
        f_done_ff <= 1'b0;
      end
    end
  end

  // start pulses and interrupt lines to the outside
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      p_start_ff <= 1'b0;
      f_start_ff <= 1'b0;
      p_irq_ff   <= 1'b0;
      w_irq_ff   <= 1'b0;
      f_irq_ff   <= 1'b0;
    end else begin
      p_start_ff <= p_accept;
      f_start_ff <= f_accept;
      // background mode keeps completion quiet, window still interrupts
      p_irq_ff   <= p_done_ff && p_ie_ff && !w_bg_ff;
      w_irq_ff   <= w_flag_ff && w_ie_ff;
      f_irq_ff   <= f_done_ff && f_ie_ff;
    end
  end

  // analog-side control registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prec_ana <= '{shutdown: 1'b1, ref_pin: 1'b0, gain: 3'h1,
                    pair_diff: 4'h0, mux_sel: 4'h0};
      fast_ana <= '{shutdown: 1'b1, ref_pin: 1'b0, gain: 2'h1, mux_sel: 3'h0};
    end else begin
      prec_ana <= '{shutdown: !p_en_ff, ref_pin: p_ref_ff, gain: p_gain_ff,
                    pair_diff: p_pair_ff, mux_sel: p_ch_ff};
      fast_ana <= '{shutdown: !f_en_ff, ref_pin: f_ref_ff, gain: f_gain_ff,
                    mux_sel: f_ch_ff};
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= conv_ctl_pkg::RST_BYTE;
    end else if (!reg_rd) begin
      rdata_ff <= conv_ctl_pkg::RST_BYTE;
    end else begin
      unique case (reg_addr)
        conv_ctl_pkg::PREC_CTL_ADDR:
          rdata_ff <= {p_ie_ff, p_busy_ff, p_done_ff, 1'b0, p_lj_ff, p_src_ff, p_en_ff};
        conv_ctl_pkg::PREC_CFG_ADDR:  rdata_ff <= {p_ref_ff, p_gain_ff, p_ch_ff};
        conv_ctl_pkg::PREC_PAIR_ADDR: rdata_ff <= {4'h0, p_pair_ff};
        conv_ctl_pkg::PREC_RESL_ADDR: rdata_ff <= p_res_ff[7:0];
        conv_ctl_pkg::PREC_RESH_ADDR: rdata_ff <= p_res_ff[15:8];
        conv_ctl_pkg::WIN_LOL_ADDR:   rdata_ff <= win_lo_ff[7:0];
        conv_ctl_pkg::WIN_LOH_ADDR:   rdata_ff <= win_lo_ff[15:8];
        conv_ctl_pkg::WIN_HIL_ADDR:   rdata_ff <= win_hi_ff[7:0];
        conv_ctl_pkg::WIN_HIH_ADDR:   rdata_ff <= win_hi_ff[15:8];
        conv_ctl_pkg::WIN_CTL_ADDR:
          rdata_ff <= {4'h0, w_bg_ff, w_flag_ff, w_ie_ff, w_inside_ff};
        conv_ctl_pkg::FAST_CTL_ADDR:
          rdata_ff <= {1'b0, f_ie_ff, f_busy_ff, f_done_ff, 1'b0, f_src_ff, f_en_ff};
        conv_ctl_pkg::FAST_CFG_ADDR:  rdata_ff <= {2'h0, f_ref_ff, f_gain_ff, f_ch_ff};
        conv_ctl_pkg::FAST_RES_ADDR:  rdata_ff <= f_res_ff;
        default:                      rdata_ff <= conv_ctl_pkg::RST_BYTE;
      endcase
    end
  end

  // outputs straight from their flip-flops
  assign reg_rdata  = rdata_ff;
  assign prec_start = p_start_ff;
  assign fast_start = f_start_ff;
  assign prec_irq   = p_irq_ff;
  assign win_irq    = w_irq_ff;
  assign fast_irq   = f_irq_ff;

endmodule // dual_adc_conversion_control

/* File: testbench/dual_adc_conversion_control_asserts.sv */
// Purpose: port-level checks for the dual converter control block
// Assumes: one clock domain, reset_n asynchronous and active low
// Notes:   irq causes allow one or two cycles of registering
`timescale 1ns/1ps
module dual_adc_conversion_control_asserts (
  input wire logic                    ref_clk,
  input wire logic                    reset_n,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  input wire conv_ctl_pkg::prec_ana_s prec_ana,
  input wire logic                    prec_start,
  input wire logic                    prec_done,
  input wire conv_ctl_pkg::fast_ana_s fast_ana,
  input wire logic                    fast_start,
  input wire logic                    fast_done,
  input wire logic                    prec_irq,
  input wire logic                    win_irq,
  input wire logic                    fast_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // a started conversion that has not finished
  sequence s_prec_busy;
    prec_start ##1 !prec_done [*3];
  endsequence

  // start pulses and their blocking conditions
  a_prec_pulse: assert property (prec_start |=> !prec_start)
    else $error("precision start longer than one cycle");
  a_fast_pulse: assert property (fast_start |=> !fast_start)
    else $error("fast start longer than one cycle");
  a_busy_no_start: assert property (s_prec_busy |=> !prec_start)
    else $error("precision start while busy");
  a_prec_off: assert property ($past(prec_ana.shutdown) && prec_ana.shutdown
    |-> !prec_start)
    else $error("precision start in shutdown");
  a_fast_off: assert property ($past(fast_ana.shutdown) && fast_ana.shutdown
    |-> !fast_start)
    else $error("fast start in shutdown");
  // precision gain and channel controls stay within the coded ranges
  a_gain_range: assert property (prec_ana.gain <= conv_ctl_pkg::P_GAIN_MAX)
    else $error("precision gain code out of range");
  a_mux_range: assert property (prec_ana.mux_sel <= conv_ctl_pkg::P_CH_TEMP)
    else $error("precision channel out of range");
  // requests rise only after a completion or a register write
  a_prec_irq_cause: assert property ($rose(prec_irq) |-> $past(prec_done) ||
    $past(prec_done, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("precision irq without cause");
  a_win_irq_cause: assert property ($rose(win_irq) |-> $past(prec_done) ||
    $past(prec_done, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("window irq without cause");
  a_fast_irq_cause: assert property ($rose(fast_irq) |-> $past(fast_done) ||
    $past(fast_done, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("fast irq without cause");
  a_irq_held: assert property ($fell(prec_irq) || $fell(win_irq) || $fell(fast_irq)
    |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("irq dropped without software write");
  a_read_slot: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data outside its slot");
endmodule // dual_adc_conversion_control_asserts

bind dual_adc_conversion_control dual_adc_conversion_control_asserts i_conv_asserts (
  .ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_rdata, .prec_ana, .prec_start, .prec_done,
  .fast_ana, .fast_start, .fast_done, .prec_irq, .win_irq, .fast_irq);

/* File: testbench/dual_adc_conversion_control_test.sv */
// Purpose: self-checking bench for the dual converter control block
// Assumes: bench plays cpu, timers, start pins and both converter cores
// Notes:   start pulses are counted so dropped or extra starts show up
`timescale 1ns/1ps
module dual_adc_conversion_control_test;
  logic                    ref_clk = 1'b0;
  logic                    reset_n = 1'b0;
  logic [7:0]              reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic                    reg_wr = 1'b0, reg_rd = 1'b0;
  logic                    tmr2_ovf = 1'b0, tmr3_ovf = 1'b0, fast_tmr_ovf = 1'b0;
  logic                    prec_ext_start = 1'b0, fast_ext_start = 1'b0;
  logic                    prec_done = 1'b0, fast_done = 1'b0;
  logic [11:0]             prec_data = 12'h000;
  logic [7:0]              fast_data = 8'h00, wctl = 8'h01;
  logic [15:0]             wlo = 16'h0000, whi = 16'hFFFF;
  conv_ctl_pkg::prec_ana_s prec_ana;
  conv_ctl_pkg::fast_ana_s fast_ana;
  logic                    prec_start, fast_start, prec_irq, win_irq, fast_irq;
  int                      fail_count = 0, comparisons = 0, prec_starts = 0, fast_starts = 0;

  dual_adc_conversion_control i_dual_adc_conversion_control (
    .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tmr2_ovf, .tmr3_ovf, .fast_tmr_ovf, .prec_ext_start, .fast_ext_start,
    .prec_ana, .prec_start, .prec_done, .prec_data, .fast_ana, .fast_start,
    .fast_done, .fast_data, .prec_irq, .win_irq, .fast_irq);

  // clock and start pulse counters
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (prec_start === 1'b1) prec_starts++;
    if (fast_start === 1'b1) fast_starts++;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // register port cycles, one strobe cycle then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask

  task automatic wait_cnt(input bit f, input int want);
    int n;
    for (n = 0; n < 30 && (f ? fast_starts : prec_starts) < want; n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (n == 30) begin
      fail_count++;
      results();
    end else begin
      @(posedge ref_clk);
    end
  endtask

  // precision triggers: bit0 software, bit1 tmr2, bit2 tmr3, bit3 pin
  task automatic fire(input logic [3:0] m, input logic [7:0] ctl);
    if (m[0]) wr(8'h00, ctl | 8'h10);
    tmr2_ovf <= m[1];
    tmr3_ovf <= m[2];
    prec_ext_start <= m[3];
    @(posedge ref_clk);
    tmr2_ovf <= 1'b0;
    tmr3_ovf <= 1'b0;
    repeat (2) @(posedge ref_clk);
    prec_ext_start <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pconv(input logic [1:0] src, input logic lj, input logic [11:0] d);
    logic [7:0]  ctl, v;
    logic [15:0] r;
    logic        w;
    int          c0;
    ctl = {4'h8, lj, src, 1'b1};
    r = lj ? {d, 4'h0} : {4'h0, d};
    w = wctl[1] && (wctl[0] == (r >= wlo && r <= whi));
    wr(8'h00, ctl);
    c0 = prec_starts;
    fire(~(4'h1 << src), ctl);
    check(prec_starts, c0);
    fire(4'h1 << src, ctl);
    wait_cnt(1'b0, c0 + 1);
    fire(4'h1 << src, ctl);
    prec_data <= d;
    prec_done <= 1'b1;
    @(posedge ref_clk);
    prec_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(prec_starts, c0 + 1);
    rd(8'h03, v);
    check(v, r[7:0]);
    rd(8'h04, v);
    check(v, r[15:8]);
    rd(8'h00, v);
    check(v[5], 1'b1);
    check(prec_irq, !wctl[3]);
    check(win_irq, w);
    wr(8'h00, ctl | 8'h20);
    wr(8'h09, wctl | 8'h04);
    @(posedge ref_clk); // irq outputs trail the flag clear by one cycle
    check({prec_irq, win_irq}, 2'b00);
    $display("precision conversion %h done", d);
  endtask

  task automatic fconv(input logic [1:0] src, input logic [7:0] d);
    logic [7:0] ctl, v;
    int         c0;
    ctl = {2'b01, 3'b000, src, 1'b1};
    c0 = fast_starts;
    wr(8'h0A, ctl);
    wr(8'h00, 8'h01);
    case (src)
      2'h0: wr(8'h0A, ctl | 8'h08);
      2'h1: begin
        fast_tmr_ovf <= 1'b1;
        @(posedge ref_clk);
        fast_tmr_ovf <= 1'b0;
      end
      2'h2: begin
        fast_ext_start <= 1'b1;
        repeat (3) @(posedge ref_clk);
        fast_ext_start <= 1'b0;
      end
      default: wr(8'h00, 8'h11);
    endcase
    wait_cnt(1'b1, c0 + 1);
    fast_data <= d;
    fast_done <= 1'b1;
    prec_done <= 1'b1;
    @(posedge ref_clk);
    fast_done <= 1'b0;
    prec_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(8'h0C, v);
    check(v, d);
    check(fast_irq, 1'b1);
    wr(8'h0A, ctl | 8'h10);
    wr(8'h00, 8'h21);
    check({fast_irq, fast_starts[3:0]}, {1'b0, 4'(c0 + 1)});
    $display("fast conversion %h done", d);
  endtask

  // reset values, unmapped place
  task automatic treset();
    logic [7:0] v;
    check(prec_ana, {1'b1, 1'b0, 3'h1, 8'h00});
    check(fast_ana, {1'b1, 1'b0, 2'h1, 3'h0});
    rd(8'h00, v);
    check(v, 8'h00);
    rd(8'h07, v);
    check(v, 8'hFF);
    rd(8'h09, v);
    check(v, 8'h01);
    wr(8'h20, 8'hA5);
    rd(8'h20, v);
    check(v, 8'h00);
    $display("reset test done");
  endtask

  task automatic setwin(input logic [15:0] lo, input logic [15:0] hi, input logic [7:0] c);
    wlo = lo;
    whi = hi;
    wctl = c;
    wr(8'h05, lo[7:0]);
    wr(8'h06, lo[15:8]);
    wr(8'h07, hi[7:0]);
    wr(8'h08, hi[15:8]);
    wr(8'h09, c);
  endtask

  // inside, outside and background windows with bound values
  task automatic twin();
    setwin(16'h0100, 16'h0200, 8'h03);
    pconv(2'h0, 1'b0, 12'h100);
    pconv(2'h0, 1'b0, 12'h200);
    pconv(2'h0, 1'b0, 12'h0FF);
    pconv(2'h0, 1'b1, 12'h010);
    setwin(16'h0100, 16'h0200, 8'h02);
    pconv(2'h0, 1'b0, 12'h201);
    pconv(2'h0, 1'b0, 12'h150);
    setwin(16'h0100, 16'h0200, 8'h0B);
    pconv(2'h0, 1'b0, 12'h180);
    $display("window test done");
  endtask

  // analog controls, saturation, shutdown
  task automatic tcfg();
    int c0;
    check({prec_ana.shutdown, fast_ana.shutdown}, 2'b00);
    wr(8'h01, 8'hF9);
    wr(8'h02, 8'h05);
    wr(8'h0B, 8'h3D);
    @(posedge ref_clk); // analog controls trail the registers by one cycle
    check(prec_ana[11:0], {1'b1, 3'h5, 4'h5, 4'h8});
    check(fast_ana[5:0], {1'b1, 2'h3, 3'h5});
    wr(8'h01, 8'h23);
    @(posedge ref_clk);
    check(prec_ana[11:0], {1'b0, 3'h2, 4'h5, 4'h3});
    wr(8'h00, 8'h00);
    wr(8'h0A, 8'h00);
    c0 = prec_starts;
    wr(8'h00, 8'h10);
    repeat (4) @(posedge ref_clk);
    check({prec_ana.shutdown, fast_ana.shutdown}, 2'b11);
    check(prec_starts, c0);
    $display("config test done");
  endtask

  initial begin
    #400000;
    fail_count++;
    results();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    treset();
    for (int s = 0; s < 4; s++) pconv(2'(s), 1'(s), 12'hA5C);
    twin();
    for (int s = 0; s < 4; s++) fconv(2'(s), 8'h3C + 8'(s));
    tcfg();
    results();
  end
endmodule // dual_adc_conversion_control_test
